//--- logic/clic_top.sv
// Cascaded pair of legacy interrupt controllers with acknowledge sequencer
`timescale 1ns/10ps
`include "clic_defs.svh"

// Behaviour
// - Secondary controller chains into primary input 2, giving 15 usable lines.
// - Primary input 0 from timer or media timer 0; secondary 0 from RTC or timer 1.
// - Per-line edge or level select; lines 0, 1, 2 and RTC forced edge.
// - Active-low sources are inverted so high always means request.
// - Pending bit set on rising edge in edge mode, by high level in level mode.
// - Pending bit sets even when masked; masked lines never raise the CPU output.
// - CPU interrupt output active while any unmasked pending request outranks every in-service line.
// - Each acknowledge transaction yields exactly two internal acknowledge pulses.
// - Primary request state is frozen for priority resolution at the first pulse, the secondary's at the start of the gap after it.
// - First pulse sets winner's in-service bit and, in edge mode, clears its pending bit; a level line's pending bit follows its input.
// - Primary sends three-bit cascade code after first pulse; secondary decides to answer.
// - Second pulse returns vector: base bits 7..3, input number bits 2..0.
// - No request at acknowledge returns primary vector for input 7.
// - Automatic mode clears the acknowledged in-service bit at second pulse end.
// - Otherwise in-service stays set until software sends an end-of-service command.
// - Input 0 highest; in-service blocks same and lower, higher still interrupt.
// - Primary cascade configuration is fixed: only bit 2 set.
module clic_top
    import clic_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic [15:0] irq_in,
    input  wire logic [15:0] shared_pci_request_n,
    input  wire logic        rtc_request_n,
    input  wire logic        timer0_out,
    input  wire logic        mm_timer0,
    input  wire logic        mm_timer1,
    input  wire logic        mm_timer_sel,
    input  wire logic [15:0] io_addr,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [7:0]  io_wdata,
    output logic [7:0]       io_rdata,
    input  wire logic        ack_req,
    output logic             ack_busy,
    output logic             ack_pulse_n,
    output logic [2:0]       cascade_id,
    output logic [7:0]       vector_out,
    output logic             vector_valid,
    output logic             cpu_irq_out
);

    localparam logic [2:0] PULSE_LAST = 3'(`CLIC_ACK_PULSE_CYC - 1);
    localparam logic [2:0] GAP_LAST   = 3'(`CLIC_ACK_GAP_CYC - 1);
    // Primary cascade wiring is fixed, not programmable
    localparam logic [7:0] CASCADE_CFG = `CLIC_CASCADE_CFG;

    clic_top_st_t st;
    clic_top_st_t nxt;

    logic [15:0] src;
    logic        t0_src;
    logic        rtc_src;
    clic_port_t  psel;
    logic        sec_match;
    logic [7:0]  ack_vec;

    logic [7:0]  c_req     [2];
    logic [7:0]  c_trig    [2];
    logic [7:0]  c_irr     [2];
    logic [7:0]  c_isr     [2];
    logic [7:0]  c_mask    [2];
    logic        c_init    [2];
    logic        c_mask_wr [2];
    logic        c_eoi_any [2];
    logic        c_eoi_spec[2];
    logic        c_take    [2];
    logic        c_auto    [2];
    logic        c_irq     [2];
    logic        c_hit     [2];
    logic [2:0]  c_idx     [2];

    // Address decode, shared by the read and write paths
    function automatic clic_port_t port_sel(input logic [15:0] a);
        clic_port_t p;
        case (a)
            `CLIC_PRI_CMD_ADDR: p = PS_PRI_CMD;
            `CLIC_PRI_DAT_ADDR: p = PS_PRI_DAT;
            `CLIC_SEC_CMD_ADDR: p = PS_SEC_CMD;
            `CLIC_SEC_DAT_ADDR: p = PS_SEC_DAT;
            `CLIC_TRIG_LO_ADDR: p = PS_TRIG_LO;
            `CLIC_TRIG_HI_ADDR: p = PS_TRIG_HI;
            default:            p = PS_NONE;
        endcase
        return p;
    endfunction

    function automatic logic is_cmd(input clic_port_t p, input int k);
        return (k == 0) ? (p == PS_PRI_CMD) : (p == PS_SEC_CMD);
    endfunction

    function automatic logic is_dat(input clic_port_t p, input int k);
        return (k == 0) ? (p == PS_PRI_DAT) : (p == PS_SEC_DAT);
    endfunction

    // Vector byte: base of the answering controller, then input number
    function automatic logic [7:0] make_vec(input logic [4:0] b, input logic [2:0] n);
        return {b, n};
    endfunction

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : gen_ctl
            clic_core u_core (
                .clk_sys    (clk_sys),
                .reset_n    (reset_n),
                .req        (c_req[g]),
                .trig_level (c_trig[g]),
                .init       (c_init[g]),
                .mask_wr    (c_mask_wr[g]),
                .mask_data  (io_wdata),
                .eoi_any    (c_eoi_any[g]),
                .eoi_spec   (c_eoi_spec[g]),
                .eoi_lvl    (io_wdata[2:0]),
                .take       (c_take[g]),
                .auto_clr   (c_auto[g]),
                .irq_out    (c_irq[g]),
                .request_pending_bits        (c_irr[g]),
                .in_service_bits        (c_isr[g]),
                .mask       (c_mask[g]),
                .win_idx    (c_idx[g]),
                .win_hit    (c_hit[g])
            );
        end
    endgenerate

    assign cpu_irq_out  = c_irq[0];
    assign ack_busy     = (st.ack != AK_IDLE);
    assign ack_pulse_n  = ~((st.ack == AK_P1) || (st.ack == AK_P2));
    assign vector_valid = (st.ack == AK_DONE);
    assign vector_out   = st.vec;
    assign cascade_id   = st.cas;
    assign io_rdata     = st.rdata;

    // Source selection and polarity; synchronised copies only
    always_comb
    begin
        src = st.in_s2 | ~st.lo_s2;
        t0_src = st.misc_s2[0] ? st.misc_s2[2] : st.misc_s2[3];
        rtc_src = st.misc_s2[0] ? st.misc_s2[1] : ~st.misc_s2[4];
        c_req[0] = {src[7:3], c_irq[1], src[1], t0_src};
        c_req[1] = {src[15:9], rtc_src};
        c_trig[0] = st.trig[7:0] & ~`CLIC_PRI_EDGE_ONLY;
        c_trig[1] = st.trig[15:8] & ~`CLIC_SEC_EDGE_ONLY;
    end

    // Acknowledge decisions, from registered sequencer state only
    always_comb
    begin
        // Secondary answers only if the primary picked its cascade input
        sec_match = c_hit[0] && (st.cas == `CLIC_CASCADE_IN) && CASCADE_CFG[`CLIC_CASCADE_IN]
                    && (st.cas == st.sec_id);
        if (c_hit[0] && (c_idx[0] != `CLIC_CASCADE_IN))
            ack_vec = make_vec(st.base[0], c_idx[0]);
        else if (c_hit[0] && st.sec_sel && c_hit[1])
            ack_vec = make_vec(st.base[1], c_idx[1]);
        else
            ack_vec = make_vec(st.base[0], `CLIC_SPURIOUS_IN);
    end

    always_comb
    begin
        nxt = st;
        nxt.in_s1 = irq_in;
        nxt.in_s2 = st.in_s1;
        nxt.lo_s1 = shared_pci_request_n;
        nxt.lo_s2 = st.lo_s1;
        nxt.misc_s1 = {rtc_request_n, timer0_out, mm_timer0, mm_timer1, mm_timer_sel};
        nxt.misc_s2 = st.misc_s1;

        psel = port_sel(io_addr);
        for (int k = 0; k < 2; k++)
        begin
            c_init[k] = 1'b0;
            c_mask_wr[k] = 1'b0;
            c_eoi_any[k] = 1'b0;
            c_eoi_spec[k] = 1'b0;
            c_take[k] = 1'b0;
            c_auto[k] = 1'b0;
        end

        // Command and data ports of each controller
        for (int k = 0; k < 2; k++)
        begin
            if (io_wr && is_cmd(psel, k))
            begin
                if (io_wdata[`CLIC_INIT_BIT])
                begin
                    // Init word restarts the setup sequence and clears the mask
                    nxt.step[k] = ST_W2;
                    nxt.ris[k] = 1'b0;
                    c_init[k] = 1'b1;
                end
                else if (io_wdata[`CLIC_SEL3_BIT])
                begin
                    if (io_wdata[`CLIC_RDSEL_BIT])
                        nxt.ris[k] = io_wdata[`CLIC_RDISR_BIT];
                end
                else if (io_wdata[`CLIC_EOI_BIT])
                begin
                    if (io_wdata[`CLIC_SPEC_BIT])
                        c_eoi_spec[k] = 1'b1;
                    else
                        c_eoi_any[k] = 1'b1;
                end
            end
            if (io_wr && is_dat(psel, k))
            begin
                case (st.step[k])
                    ST_W2:
                    begin
                        nxt.base[k] = io_wdata[7:3];
                        nxt.step[k] = ST_W3;
                    end
                    ST_W3:
                    begin
                        // Primary cascade wiring is fixed, its written value is dropped
                        if (k == 1)
                            nxt.sec_id = io_wdata[2:0];
                        nxt.step[k] = ST_W4;
                    end
                    ST_W4:
                    begin
                        nxt.auto_clr[k] = io_wdata[`CLIC_AUTO_BIT];
                        nxt.step[k] = ST_READY;
                    end
                    default:
                        c_mask_wr[k] = 1'b1;
                endcase
            end
        end

        // Stored as written; forced-edge lines are masked where used
        if (io_wr && (psel == PS_TRIG_LO))
            nxt.trig[7:0] = io_wdata;
        if (io_wr && (psel == PS_TRIG_HI))
            nxt.trig[15:8] = io_wdata;

        // Registered read data holds until the next read
        if (io_rd)
        begin
            case (psel)
                PS_PRI_CMD: nxt.rdata = st.ris[0] ? c_isr[0] : c_irr[0];
                PS_SEC_CMD: nxt.rdata = st.ris[1] ? c_isr[1] : c_irr[1];
                PS_PRI_DAT: nxt.rdata = c_mask[0];
                PS_SEC_DAT: nxt.rdata = c_mask[1];
                PS_TRIG_LO: nxt.rdata = st.trig[7:0];
                PS_TRIG_HI: nxt.rdata = st.trig[15:8];
                default:    nxt.rdata = `CLIC_UNMAPPED_DATA;
            endcase
        end

        // Acknowledge sequencer: one transaction, two internal pulses
        case (st.ack)
            AK_IDLE:
            begin
                // Requests while busy are dropped, never queued
                if (ack_req)
                begin
                    nxt.ack = AK_P1;
                    nxt.cnt = 3'h0;
                    nxt.sec_sel = 1'b0;
                    c_take[0] = 1'b1;
                end
            end
            AK_P1:
            begin
                if (st.cnt == PULSE_LAST)
                begin
                    // Trailing edge of first pulse: broadcast winner code
                    nxt.ack = AK_GAP;
                    nxt.cnt = 3'h0;
                    nxt.cas = c_idx[0];
                end
                else
                    nxt.cnt = 3'(st.cnt + 3'h1);
            end
            AK_GAP:
            begin
                if ((st.cnt == 3'h0) && sec_match)
                begin
                    c_take[1] = 1'b1;
                    nxt.sec_sel = 1'b1;
                end
                if (st.cnt == GAP_LAST)
                begin
                    nxt.ack = AK_P2;
                    nxt.cnt = 3'h0;
                end
                else
                    nxt.cnt = 3'(st.cnt + 3'h1);
            end
            AK_P2:
            begin
                if (st.cnt == PULSE_LAST)
                begin
                    nxt.ack = AK_DONE;
                    nxt.cnt = 3'h0;
                    nxt.vec = ack_vec;
                end
                else
                    nxt.cnt = 3'(st.cnt + 3'h1);
            end
            AK_DONE:
            begin
                // End of second pulse; secondary cleared only if it answered
                c_auto[0] = st.auto_clr[0];
                c_auto[1] = st.auto_clr[1] & st.sec_sel;
                nxt.ack = AK_IDLE;
            end
            default:
                nxt.ack = AK_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st <= '0;
            // Low-active synchronisers start idle: no false edge after reset
            st.lo_s1 <= `CLIC_LOW_SYNC_RST;
            st.lo_s2 <= `CLIC_LOW_SYNC_RST;
            st.misc_s1 <= `CLIC_MISC_SYNC_RST;
            st.misc_s2 <= `CLIC_MISC_SYNC_RST;
            st.sec_id <= `CLIC_SEC_ID_RST;
            st.base <= {`CLIC_BASE_RST, `CLIC_BASE_RST};
        end
        else
            st <= nxt;
    end

endmodule

//--- logic/clic_defs.svh
// Constants for the cascaded legacy interrupt controller
`ifndef CLIC_DEFS_SVH
`define CLIC_DEFS_SVH

`define CLIC_PRI_CMD_ADDR   16'h0020
`define CLIC_PRI_DAT_ADDR   16'h0021
`define CLIC_SEC_CMD_ADDR   16'h00A0
`define CLIC_SEC_DAT_ADDR   16'h00A1
`define CLIC_TRIG_LO_ADDR   16'h04D0
`define CLIC_TRIG_HI_ADDR   16'h04D1

`define CLIC_INIT_BIT       4
`define CLIC_SEL3_BIT       3
`define CLIC_EOI_BIT        5
`define CLIC_SPEC_BIT       6
`define CLIC_RDSEL_BIT      1
`define CLIC_RDISR_BIT      0
`define CLIC_AUTO_BIT       1

`define CLIC_CASCADE_CFG    8'h04
`define CLIC_CASCADE_IN     3'h2
`define CLIC_SPURIOUS_IN    3'h7
`define CLIC_SEC_ID_RST     3'h2
`define CLIC_BASE_RST       5'h00
`define CLIC_PRI_EDGE_ONLY  8'h07
`define CLIC_SEC_EDGE_ONLY  8'h01
`define CLIC_LOW_SYNC_RST   16'hFFFF
`define CLIC_MISC_SYNC_RST  5'h10
`define CLIC_UNMAPPED_DATA  8'h00

`define CLIC_CLK_MHZ        50
`define CLIC_ACK_PULSE_NS   40
`define CLIC_ACK_GAP_NS     40
`define CLIC_ACK_PULSE_CYC  ((`CLIC_ACK_PULSE_NS * `CLIC_CLK_MHZ + 999) / 1000)
`define CLIC_ACK_GAP_CYC    ((`CLIC_ACK_GAP_NS * `CLIC_CLK_MHZ + 999) / 1000)

`endif

//--- logic/clic_pkg.sv
// Types shared by the interrupt controller modules
package clic_pkg;

    typedef enum logic [2:0] {AK_IDLE, AK_P1, AK_GAP, AK_P2, AK_DONE} clic_ack_t;
    typedef enum logic [1:0] {ST_READY, ST_W2, ST_W3, ST_W4} clic_step_t;
    typedef enum logic [2:0] {PS_NONE, PS_PRI_CMD, PS_PRI_DAT, PS_SEC_CMD, PS_SEC_DAT,
                              PS_TRIG_LO, PS_TRIG_HI} clic_port_t;

    typedef struct packed {
        logic [7:0] request_pending_bits;
        logic [7:0] in_service_bits;
        logic [7:0] mask;
        logic [7:0] prev;
        logic [2:0] idx;
        logic       hit;
    } clic_core_st_t;

    typedef struct packed {
        logic [15:0]           in_s1;
        logic [15:0]           in_s2;
        logic [15:0]           lo_s1;
        logic [15:0]           lo_s2;
        logic [4:0]            misc_s1;
        logic [4:0]            misc_s2;
        clic_ack_t             ack;
        logic [2:0]            cnt;
        logic [2:0]            cas;
        logic                  sec_sel;
        logic [7:0]            vec;
        clic_step_t [1:0]      step;
        logic [1:0][4:0]       base;
        logic [1:0]            auto_clr;
        logic [1:0]            ris;
        logic [2:0]            sec_id;
        logic [15:0]           trig;
        logic [7:0]            rdata;
    } clic_top_st_t;

endpackage

//--- logic/clic_core.sv
// One eight-input controller: request, service and mask bits, priority
`timescale 1ns/10ps
`include "clic_defs.svh"

module clic_core
    import clic_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic [7:0] req,
    input  wire logic [7:0] trig_level,
    input  wire logic       init,
    input  wire logic       mask_wr,
    input  wire logic [7:0] mask_data,
    input  wire logic       eoi_any,
    input  wire logic       eoi_spec,
    input  wire logic [2:0] eoi_lvl,
    input  wire logic       take,
    input  wire logic       auto_clr,
    output logic            irq_out,
    output logic [7:0]      request_pending_bits,
    output logic [7:0]      in_service_bits,
    output logic [7:0]      mask,
    output logic [2:0]      win_idx,
    output logic            win_hit
);

    clic_core_st_t st;
    clic_core_st_t nxt;
    logic [7:0]    cand;
    logic [7:0]    rise;
    logic [7:0]    clr;
    logic [7:0]    isr_set;
    logic [7:0]    isr_clr;

    // Lowest set index, i.e. highest priority
    function automatic logic [2:0] first_set(input logic [7:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 7; i >= 0; i--)
        begin
            if (v[i])
                r = 3'(i);
        end
        return r;
    endfunction

    function automatic logic [7:0] onehot(input logic [2:0] n);
        return 8'(8'h01 << n);
    endfunction

    // Inputs strictly above the highest one in service
    function automatic logic [7:0] above(input logic [7:0] s);
        logic [7:0] m;
        logic       blk;
        blk = 1'b0;
        m = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            blk = blk | s[i];
            m[i] = ~blk;
        end
        return m;
    endfunction

    assign cand    = st.request_pending_bits & ~st.mask & above(st.in_service_bits);
    assign irq_out = |cand;
    assign request_pending_bits     = st.request_pending_bits;
    assign in_service_bits     = st.in_service_bits;
    assign mask    = st.mask;
    assign win_idx = st.idx;
    assign win_hit = st.hit;

    always_comb
    begin
        nxt = st;
        nxt.prev = req;
        rise = req & ~st.prev;
        clr = 8'h00;
        isr_set = 8'h00;
        isr_clr = 8'h00;
        if (take)
        begin
            nxt.hit = |cand;
            nxt.idx = first_set(cand);
            if (|cand)
            begin
                clr = onehot(first_set(cand));
                isr_set = onehot(first_set(cand));
            end
        end
        if (auto_clr && st.hit)
            isr_clr = isr_clr | onehot(st.idx);
        if (eoi_any)
            isr_clr = isr_clr | (onehot(first_set(st.in_service_bits)) & st.in_service_bits);
        if (eoi_spec)
            isr_clr = isr_clr | onehot(eoi_lvl);
        // Masked lines still latch; level lines follow the input
        nxt.request_pending_bits = (st.request_pending_bits & ~clr & ~trig_level) | (rise & ~trig_level) | (req & trig_level);
        nxt.in_service_bits = (st.in_service_bits & ~isr_clr) | isr_set;
        if (mask_wr)
            nxt.mask = mask_data;
        if (init)
        begin
            nxt.request_pending_bits = 8'h00;
            nxt.mask = 8'h00;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            st <= '0;
        else
            st <= nxt;
    end

endmodule

//--- test/clic_top_assertions.sv
// Timing checker for the acknowledge sequencer and read port
`timescale 1ns/10ps

module clic_top_checker
(
    input wire logic       clk_sys,
    input wire logic       reset_n,
    input wire logic       io_rd,
    input wire logic [7:0] io_rdata,
    input wire logic       ack_req,
    input wire logic       ack_busy,
    input wire logic       ack_pulse_n,
    input wire logic [2:0] cascade_id,
    input wire logic [7:0] vector_out,
    input wire logic       vector_valid,
    input wire logic       cpu_irq_out
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    logic take;
    assign take = ack_req && !ack_busy;

    property p_two_pulses;
        take |=> !ack_pulse_n [*2] ##1 ack_pulse_n [*2] ##1 !ack_pulse_n [*2] ##1 (ack_pulse_n && vector_valid);
    endproperty
    a_two_pulses: assert property (p_two_pulses) else $error("acknowledge pulse train wrong");
    property p_busy_span;
        take |=> ack_busy [*7] ##1 !ack_busy;
    endproperty
    a_busy_span: assert property (p_busy_span) else $error("busy span wrong");
    property p_pulse_in_busy;
        !ack_pulse_n |-> ack_busy;
    endproperty
    a_pulse_in_busy: assert property (p_pulse_in_busy) else $error("pulse outside sequence");
    property p_vec_cause;
        vector_valid |-> $past(take, 7);
    endproperty
    a_vec_cause: assert property (p_vec_cause) else $error("vector without acknowledge");
    property p_vec_once;
        vector_valid |=> !vector_valid;
    endproperty
    a_vec_once: assert property (p_vec_once) else $error("vector strobe too long");
    property p_vec_hold;
        $changed(vector_out) |-> vector_valid;
    endproperty
    a_vec_hold: assert property (p_vec_hold) else $error("vector moved off strobe");
    property p_cas_time;
        $changed(cascade_id) |-> ack_pulse_n && !$past(ack_pulse_n);
    endproperty
    a_cas_time: assert property (p_cas_time) else $error("cascade code off first trailing edge");
    property p_rd_hold;
        !$past(io_rd) |-> $stable(io_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");

    c_take: cover property (take);
    c_sec: cover property (vector_valid && cascade_id == 3'h2);
    c_irq: cover property ($rose(cpu_irq_out));
endmodule

bind clic_top clic_top_checker u_chk (.clk_sys, .reset_n, .io_rd, .io_rdata, .ack_req, .ack_busy,
    .ack_pulse_n, .cascade_id, .vector_out, .vector_valid, .cpu_irq_out);

//--- test/clic_host_model.sv
// Processor side: answers the interrupt output with one acknowledge
`timescale 1ns/10ps

module clic_host_model
(
    input wire logic       clk_sys,
    input wire logic       cpu_irq_out,
    input wire logic       vector_valid,
    input wire logic [7:0] vector_out,
    input wire logic       go,
    input wire logic       unsol,
    input wire logic [3:0] dly,
    output logic           ack_req,
    output logic           got,
    output logic [7:0]     got_vec
);
    // One acknowledge per go strobe; unsol asks for one with nothing pending
    initial
    begin
        ack_req = 1'b0;
        got = 1'b0;
        got_vec = 8'h00;
        forever
        begin
            @(posedge clk_sys);
            if (go === 1'b1)
            begin
                repeat (dly) @(posedge clk_sys);
                // Outputs are looked at just after the edge, once settled
                #1;
                while (!(cpu_irq_out === 1'b1 || unsol === 1'b1))
                begin
                    @(posedge clk_sys);
                    #1;
                end
                ack_req = 1'b1;
                @(posedge clk_sys);
                #1 ack_req = 1'b0;
                while (vector_valid !== 1'b1)
                begin
                    @(posedge clk_sys);
                    #1;
                end
                got_vec = vector_out;
                got = 1'b1;
                @(posedge clk_sys);
                #1 got = 1'b0;
            end
        end
    end
endmodule

//--- test/clic_top_bench.sv
// Directed bench for the cascaded interrupt controller pair
`timescale 1ns/10ps
`include "clic_defs.svh"

module clic_top_bench;
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic [15:0] irq_in = 16'h0000;
    logic [15:0] pci_n = 16'hFFFF;
    logic        rtc_n = 1'b1;
    logic        tmr0 = 1'b0;
    logic        mm0 = 1'b0;
    logic        mm1 = 1'b0;
    logic        msel = 1'b0;
    logic [15:0] io_addr = 16'h0000;
    logic        io_wr = 1'b0;
    logic        io_rd = 1'b0;
    logic [7:0]  io_wdata = 8'h00;
    logic        go = 1'b0;
    logic        unsol = 1'b0;
    logic [3:0]  dly = 4'h0;
    wire [7:0]   io_rdata, vector_out, got_vec;
    wire [2:0]   cascade_id;
    wire         ack_req, ack_busy, ack_pulse_n, vector_valid, cpu_irq_out, got;
    int          fail_count = 0;
    int          check_count = 0;

    always #10 clk_sys = ~clk_sys;

    clic_top dut (.clk_sys(clk_sys), .reset_n(reset_n), .irq_in(irq_in), .shared_pci_request_n(pci_n),
        .rtc_request_n(rtc_n), .timer0_out(tmr0), .mm_timer0(mm0), .mm_timer1(mm1), .mm_timer_sel(msel),
        .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .ack_req(ack_req), .ack_busy(ack_busy), .ack_pulse_n(ack_pulse_n), .cascade_id(cascade_id),
        .vector_out(vector_out), .vector_valid(vector_valid), .cpu_irq_out(cpu_irq_out));
    clic_host_model host (.clk_sys(clk_sys), .cpu_irq_out(cpu_irq_out), .vector_valid(vector_valid),
        .vector_out(vector_out), .go(go), .unsol(unsol), .dly(dly), .ack_req(ack_req), .got(got),
        .got_vec(got_vec));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1 io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(posedge clk_sys);
        #1 io_wr = 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string name);
        @(posedge clk_sys);
        #1 io_addr = a;
        io_rd = 1'b1;
        @(posedge clk_sys);
        #1 io_rd = 1'b0;
        chk(name, exp, io_rdata);
    endtask

    // Sync plus pending register take three cycles; five leaves margin
    task automatic irq(input logic exp);
        repeat (5) @(posedge clk_sys);
        #1 chk("cpu_irq", {7'h00, exp}, {7'h00, cpu_irq_out});
    endtask

    task automatic ack(input logic u, input logic [3:0] d, input logic [7:0] exp);
        int n;
        @(posedge clk_sys);
        #1 go = 1'b1;
        unsol = u;
        dly = d;
        @(posedge clk_sys);
        #1 go = 1'b0;
        n = 0;
        while (got !== 1'b1 && n < 200)
        begin
            @(posedge clk_sys);
            #2 n++;
        end
        if (n == 200)
            fail_count++;
        chk("vector", exp, got_vec);
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        stop_test();
    end

    initial
    begin
        repeat (20) @(posedge clk_sys);
        #1 reset_n = 1'b1;
        rd(`CLIC_PRI_DAT_ADDR, 8'h00, "mask_reset");
        rd(`CLIC_TRIG_LO_ADDR, 8'h00, "trig_reset");
        wr(`CLIC_PRI_CMD_ADDR, 8'h11);
        wr(`CLIC_PRI_DAT_ADDR, 8'h20);
        wr(`CLIC_PRI_DAT_ADDR, `CLIC_CASCADE_CFG);
        wr(`CLIC_PRI_DAT_ADDR, 8'h01);
        wr(`CLIC_SEC_CMD_ADDR, 8'h11);
        wr(`CLIC_SEC_DAT_ADDR, 8'h28);
        wr(`CLIC_SEC_DAT_ADDR, 8'h02);
        wr(`CLIC_SEC_DAT_ADDR, 8'h03);
        wr(`CLIC_PRI_DAT_ADDR, 8'hA5);
        rd(`CLIC_PRI_DAT_ADDR, 8'hA5, "mask");
        wr(`CLIC_TRIG_LO_ADDR, 8'h0A);
        rd(`CLIC_TRIG_LO_ADDR, 8'h0A, "trig");
        wr(`CLIC_TRIG_HI_ADDR, 8'h01);
        rd(`CLIC_TRIG_HI_ADDR, 8'h01, "trig_hi");
        rd(16'h0030, `CLIC_UNMAPPED_DATA, "unmapped");
        wr(`CLIC_PRI_DAT_ADDR, 8'h08);
        irq_in[3] = 1'b1;
        irq(1'b0);
        rd(`CLIC_PRI_CMD_ADDR, 8'h08, "pending");
        wr(`CLIC_PRI_DAT_ADDR, 8'h00);
        irq(1'b1);
        ack(1'b0, 4'h5, 8'h23);
        chk("cascade", 8'h03, {5'h00, cascade_id});
        irq_in[3] = 1'b0;
        irq_in[5] = 1'b1;
        irq(1'b0);
        wr(`CLIC_PRI_CMD_ADDR, 8'h0B);
        rd(`CLIC_PRI_CMD_ADDR, 8'h08, "in_service");
        irq_in[1] = 1'b1;
        irq(1'b1);
        ack(1'b0, 4'h0, 8'h21);
        wr(`CLIC_PRI_CMD_ADDR, 8'h20);
        irq(1'b0);
        wr(`CLIC_PRI_CMD_ADDR, 8'h20);
        irq(1'b1);
        ack(1'b0, 4'h0, 8'h25);
        wr(`CLIC_PRI_CMD_ADDR, 8'h65);
        rd(`CLIC_PRI_CMD_ADDR, 8'h00, "eoi_specific");
        // Lines 1 and 5 stay high; edge mode must not fire again
        irq(1'b0);
        pci_n[10] = 1'b0;
        irq(1'b1);
        ack(1'b0, 4'h0, 8'h2A);
        chk("cascade", 8'h02, {5'h00, cascade_id});
        wr(`CLIC_SEC_CMD_ADDR, 8'h0B);
        rd(`CLIC_SEC_CMD_ADDR, 8'h00, "sec_in_service");
        wr(`CLIC_PRI_CMD_ADDR, 8'h20);
        pci_n[10] = 1'b1;
        rtc_n = 1'b0;
        irq(1'b1);
        ack(1'b0, 4'h0, 8'h28);
        wr(`CLIC_PRI_CMD_ADDR, 8'h20);
        rtc_n = 1'b1;
        tmr0 = 1'b1;
        irq(1'b1);
        ack(1'b0, 4'h0, 8'h20);
        wr(`CLIC_PRI_CMD_ADDR, 8'h20);
        tmr0 = 1'b0;
        irq(1'b0);
        msel = 1'b1;
        mm0 = 1'b1;
        irq(1'b1);
        ack(1'b0, 4'h0, 8'h20);
        wr(`CLIC_PRI_CMD_ADDR, 8'h20);
        mm0 = 1'b0;
        mm1 = 1'b1;
        irq(1'b1);
        ack(1'b0, 4'h0, 8'h28);
        wr(`CLIC_PRI_CMD_ADDR, 8'h20);
        mm1 = 1'b0;
        msel = 1'b0;
        ack(1'b1, 4'h0, 8'h27);
        stop_test();
    end
endmodule
